// >>> hdl/hcub_pkg.sv
// Constants and state types for the checksum and UART break command port.
package hcub_pkg;
  // Checksum polynomial x^8 + x^2 + x + 1 as a nine-bit pattern.
  localparam logic [8:0] CRC_POLY = 9'h107;
  localparam int FRAME_BITS_CRC = 32;
  localparam int FRAME_BITS_PLAIN = 24;
  // Clock rate and UART bit periods.
  localparam int CLK_HZ = 200_000_000;
  localparam int BAUD_FAST = 9600;
  localparam int BAUD_SLOW = 1200;
  localparam int BIT_CYCLES_FAST = CLK_HZ / BAUD_FAST;
  localparam int BIT_CYCLES_SLOW = CLK_HZ / BAUD_SLOW;
  localparam int BAUD_CNT_W = 18;
  // Start, eight data, odd parity and stop.
  localparam int CHAR_BITS = 11;
  localparam logic [3:0] LAST_BIT_IDX = 4'ha;
  localparam int TX_CHARS = 4;
  localparam logic [5:0] TX_PACKET_BITS = 6'h2c;
  // Address of the register that holds the UART register-access bit.
  localparam logic [6:0] BREAK_REG_ADDR = 7'h7e;
  localparam int ERR_CNT_W = 4;
  localparam logic [ERR_CNT_W-1:0] ERR_CNT_RESET = 4'h0;
  localparam logic [ERR_CNT_W-1:0] ERR_CNT_MAX = 4'hf;
  localparam logic UART_ACCESS_RESET = 1'b0;
  typedef enum logic [1:0] {HCUB_RX_IDLE = 2'b01, HCUB_RX_BITS = 2'b10} hcub_rx_type;
  typedef enum logic [1:0] {HCUB_TX_IDLE = 2'b01, HCUB_TX_SEND = 2'b10} hcub_tx_type;
endpackage

// >>> hdl/hcub_port.sv
// Frame checksum checking and UART break-mode command port.
`timescale 1ns/10ps
`default_nettype none

module hcub_port
  import hcub_pkg::*;
#(
  parameter logic [BAUD_CNT_W-1:0] BIT_FAST = BAUD_CNT_W'(BIT_CYCLES_FAST),
  parameter logic [BAUD_CNT_W-1:0] BIT_SLOW = BAUD_CNT_W'(BIT_CYCLES_SLOW)
) (
  // Clock, reset and enable.
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic clk_en,
  // Configuration bits.
  input wire logic checksum_enable,
  input wire logic [ERR_CNT_W-1:0] error_limit,
  input wire logic fault_mask,
  input wire logic alarm_action_enable,
  input wire logic uart_fast_baud,
  input wire logic break_event_enable,
  // Serial frame side.
  input wire logic spi_frame_done,
  input wire logic [31:0] spi_frame_bits,
  input wire logic [23:0] spi_read_data,
  input wire logic status_read_start,
  input wire logic status_read_end,
  // Status sources for break-mode packets.
  input wire logic alarm_event_flag,
  input wire logic general_event_flag,
  input wire logic modem_event_flag,
  input wire logic [15:0] alarm_status_word,
  input wire logic [15:0] general_state_register,
  input wire logic [15:0] modem_status_word,
  input wire logic read_resp_valid,
  input wire logic [15:0] read_resp_word,
  // UART pins.
  input wire logic uart_rx_pin,
  output logic uart_tx_pin,
  // Checksum status and alarm pin.
  output logic [31:0] spi_out_frame,
  output logic checksum_error_status,
  output logic [ERR_CNT_W-1:0] checksum_error_count,
  output logic checksum_fault_flag,
  output logic alarm_irq_status,
  output logic alarm_pin_out,
  output logic alarm_pin_oe,
  // Register commands.
  output logic cmd_valid,
  output logic cmd_read,
  output logic [6:0] cmd_addr,
  output logic [15:0] cmd_data,
  output logic cmd_from_uart,
  output logic uart_reg_access,
  // UART data and character status.
  output logic modem_rx_valid,
  output logic [7:0] modem_rx_data,
  output logic uart_parity_error,
  output logic uart_stop_error,
  output logic tx_busy
);

  // Checksum over 24 bits, most significant bit first, remainder from zero.
  function automatic logic [7:0] crc8(input logic [23:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 23; i >= 0; i--) begin
      if (c[7] ^ d[i]) begin
        c = (c << 1) ^ CRC_POLY[7:0];
      end else begin
        c = c << 1;
      end
    end
    return c;
  endfunction

  // One UART character, least significant bit leaves first.
  function automatic logic [10:0] uart_char(input logic [7:0] d);
    return {1'b1, ~^d, d, 1'b0};
  endfunction

  logic [BAUD_CNT_W-1:0] bit_len;
  assign bit_len = uart_fast_baud ? BIT_FAST : BIT_SLOW;

  // Serial frame checking and command staging.
  logic [23:0] spi_payload;
  logic spi_crc_ok;
  logic pend_valid, pend_read, pend_uart;
  logic [6:0] pend_addr;
  logic [15:0] pend_data;
  logic next_pend_valid, next_pend_read, next_pend_uart;
  logic [6:0] next_pend_addr;
  logic [15:0] next_pend_data;
  logic next_cmd_valid, next_err_status, next_fault, next_access;
  logic [ERR_CNT_W-1:0] next_count;
  logic [31:0] next_out_frame;
  logic uart_cmd_valid;
  logic [23:0] uart_cmd_word;

  always_comb begin
    spi_payload = checksum_enable ? spi_frame_bits[31:8] : spi_frame_bits[23:0];
    spi_crc_ok = !checksum_enable || (crc8(spi_payload) == spi_frame_bits[7:0]);
    next_pend_valid = 1'b0;
    next_pend_read = pend_read;
    next_pend_addr = pend_addr;
    next_pend_data = pend_data;
    next_pend_uart = pend_uart;
    next_err_status = checksum_error_status;
    next_count = checksum_error_count;
    next_fault = checksum_fault_flag;
    next_access = uart_reg_access;
    if (uart_cmd_valid) begin
      // Break register is reachable only here; others only once access is set.
      if (uart_cmd_word[22:16] == BREAK_REG_ADDR || uart_reg_access) begin
        next_pend_valid = 1'b1;
        {next_pend_read, next_pend_addr, next_pend_data} = uart_cmd_word;
        next_pend_uart = 1'b1;
      end
    end else if (spi_frame_done) begin
      next_err_status = !spi_crc_ok;
      if (!spi_crc_ok) begin
        if (checksum_error_count != ERR_CNT_MAX) begin
          next_count = checksum_error_count + 1'b1;
        end
      end else if (!uart_reg_access && spi_payload[22:16] != BREAK_REG_ADDR) begin
        next_pend_valid = 1'b1;
        {next_pend_read, next_pend_addr, next_pend_data} = spi_payload;
        next_pend_uart = 1'b0;
      end
    end
    // Sticky fault: cleared at readback start, relatched at its end.
    if (status_read_start) begin
      next_fault = 1'b0;
    end
    if (status_read_end && error_limit != 4'h0 && checksum_error_count >= error_limit) begin
      next_fault = 1'b1;
    end
    if (error_limit != 4'h0 && next_count == error_limit && next_count != checksum_error_count) begin
      next_fault = 1'b1;
    end
    next_cmd_valid = pend_valid;
    if (pend_valid && !pend_read && pend_uart && pend_addr == BREAK_REG_ADDR) begin
      next_access = pend_data[0];
    end
    if (checksum_enable) begin
      next_out_frame = {spi_read_data, crc8(spi_read_data)};
    end else begin
      next_out_frame = {8'h00, spi_read_data};
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pend_valid <= 1'b0;
      pend_read <= 1'b0;
      pend_addr <= 7'h00;
      pend_data <= 16'h0000;
      pend_uart <= 1'b0;
      cmd_valid <= 1'b0;
      cmd_read <= 1'b0;
      cmd_addr <= 7'h00;
      cmd_data <= 16'h0000;
      cmd_from_uart <= 1'b0;
      checksum_error_status <= 1'b0;
      checksum_error_count <= ERR_CNT_RESET;
      checksum_fault_flag <= 1'b0;
      alarm_irq_status <= 1'b0;
      alarm_pin_out <= 1'b0;
      alarm_pin_oe <= 1'b0;
      uart_reg_access <= UART_ACCESS_RESET;
      spi_out_frame <= 32'h0000_0000;
    end else if (clk_en) begin
      pend_valid <= next_pend_valid;
      pend_read <= next_pend_read;
      pend_addr <= next_pend_addr;
      pend_data <= next_pend_data;
      pend_uart <= next_pend_uart;
      cmd_valid <= next_cmd_valid;
      cmd_read <= pend_read;
      cmd_addr <= pend_addr;
      cmd_data <= pend_data;
      cmd_from_uart <= pend_uart;
      checksum_error_status <= next_err_status;
      checksum_error_count <= next_count;
      checksum_fault_flag <= next_fault;
      alarm_irq_status <= next_fault && !fault_mask;
      alarm_pin_out <= 1'b0;
      alarm_pin_oe <= next_fault && !fault_mask && alarm_action_enable;
      uart_reg_access <= next_access;
      spi_out_frame <= next_out_frame;
    end
  end

  // UART receiver: samples mid-bit, finds breaks and assembles packets.
  hcub_rx_type rx_state, next_rx_state;
  logic [BAUD_CNT_W-1:0] rx_cnt, next_rx_cnt;
  logic [3:0] rx_idx, next_rx_idx;
  logic [10:0] rx_bits, next_rx_bits;
  logic rx_armed, next_rx_armed;
  logic [1:0] pkt_left, next_pkt_left;
  logic [15:0] pkt_word, next_pkt_word;
  logic next_modem_valid, next_par_err, next_stop_err;
  logic [7:0] next_modem_data;
  logic [23:0] next_uart_cmd_word;
  logic next_uart_cmd_valid;

  always_comb begin
    next_rx_state = rx_state;
    next_rx_cnt = rx_cnt;
    next_rx_idx = rx_idx;
    next_rx_bits = rx_bits;
    next_rx_armed = rx_armed;
    next_pkt_left = pkt_left;
    next_pkt_word = pkt_word;
    next_modem_valid = 1'b0;
    next_modem_data = modem_rx_data;
    next_par_err = 1'b0;
    next_stop_err = 1'b0;
    next_uart_cmd_valid = 1'b0;
    next_uart_cmd_word = uart_cmd_word;
    unique case (rx_state)
      HCUB_RX_IDLE: begin
        if (uart_rx_pin) begin
          next_rx_armed = 1'b1;
        end else if (rx_armed) begin
          next_rx_state = HCUB_RX_BITS;
          next_rx_cnt = bit_len >> 1;
          next_rx_idx = 4'h0;
        end
      end
      HCUB_RX_BITS: begin
        if (rx_cnt != '0) begin
          next_rx_cnt = rx_cnt - 1'b1;
        end else begin
          next_rx_bits = {uart_rx_pin, rx_bits[10:1]};
          next_rx_cnt = bit_len - 1'b1;
          next_rx_idx = rx_idx + 1'b1;
          if (rx_idx == LAST_BIT_IDX) begin
            next_rx_state = HCUB_RX_IDLE;
            next_rx_armed = 1'b0;
            if (next_rx_bits == 11'h000) begin
              // A break raises no parity or stop error.
              next_pkt_left = uart_fast_baud ? 2'h3 : 2'h0;
            end else if (!(^next_rx_bits[9:1]) || !next_rx_bits[10]) begin
              next_par_err = !(^next_rx_bits[9:1]);
              next_stop_err = !next_rx_bits[10];
              next_pkt_left = 2'h0;
            end else if (pkt_left != 2'h0) begin
              next_pkt_left = pkt_left - 1'b1;
              next_pkt_word = {pkt_word[7:0], next_rx_bits[8:1]};
              if (pkt_left == 2'h1) begin
                next_uart_cmd_valid = 1'b1;
                next_uart_cmd_word = {pkt_word, next_rx_bits[8:1]};
              end
            end else begin
              next_modem_valid = 1'b1;
              next_modem_data = next_rx_bits[8:1];
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rx_state <= HCUB_RX_IDLE;
      rx_cnt <= '0;
      rx_idx <= 4'h0;
      rx_bits <= 11'h7ff;
      rx_armed <= 1'b0;
      pkt_left <= 2'h0;
      pkt_word <= 16'h0000;
      modem_rx_valid <= 1'b0;
      modem_rx_data <= 8'h00;
      uart_parity_error <= 1'b0;
      uart_stop_error <= 1'b0;
      uart_cmd_valid <= 1'b0;
      uart_cmd_word <= 24'h000000;
    end else if (clk_en) begin
      rx_state <= next_rx_state;
      rx_cnt <= next_rx_cnt;
      rx_idx <= next_rx_idx;
      rx_bits <= next_rx_bits;
      rx_armed <= next_rx_armed;
      pkt_left <= next_pkt_left;
      pkt_word <= next_pkt_word;
      modem_rx_valid <= next_modem_valid;
      modem_rx_data <= next_modem_data;
      uart_parity_error <= next_par_err;
      uart_stop_error <= next_stop_err;
      uart_cmd_valid <= next_uart_cmd_valid;
      uart_cmd_word <= next_uart_cmd_word;
    end
  end

  // UART transmitter: break then three characters for replies and events.
  hcub_tx_type tx_state, next_tx_state;
  logic [BAUD_CNT_W-1:0] tx_cnt, next_tx_cnt;
  logic [5:0] tx_left, next_tx_left;
  logic [43:0] tx_shift, next_tx_shift;
  logic read_pend, next_read_pend;
  logic [15:0] read_word, next_read_word;
  logic any_event, event_seen, event_pend, next_event_pend;
  logic next_tx_pin;
  logic [23:0] tx_payload;

  always_comb begin
    any_event = alarm_event_flag || general_event_flag || modem_event_flag;
    next_tx_state = tx_state;
    next_tx_cnt = tx_cnt;
    next_tx_left = tx_left;
    next_tx_shift = tx_shift;
    next_read_pend = read_pend;
    next_read_word = read_word;
    next_event_pend = event_pend;
    tx_payload = 24'h000000;
    if (read_resp_valid && uart_fast_baud) begin
      next_read_pend = 1'b1;
      next_read_word = read_resp_word;
    end
    if (any_event && !event_seen && break_event_enable && uart_fast_baud) begin
      next_event_pend = 1'b1;
    end
    unique case (tx_state)
      HCUB_TX_IDLE: begin
        if (read_pend || event_pend) begin
          if (read_pend) begin
            tx_payload = {1'b1, alarm_event_flag, general_event_flag, modem_event_flag,
                          4'h0, read_word};
            next_read_pend = read_resp_valid && uart_fast_baud;
          end else begin
            next_event_pend = 1'b0;
            tx_payload[23:20] = {1'b0, alarm_event_flag, general_event_flag,
                                 modem_event_flag};
            if (alarm_event_flag) begin
              tx_payload[15:0] = alarm_status_word;
            end else if (general_event_flag) begin
              tx_payload[15:0] = general_state_register;
            end else begin
              tx_payload[15:0] = modem_status_word;
            end
          end
          if (any_event || read_pend) begin
            next_tx_state = HCUB_TX_SEND;
            next_tx_shift = {uart_char(tx_payload[7:0]), uart_char(tx_payload[15:8]),
                             uart_char(tx_payload[23:16]), 11'h000};
            next_tx_left = TX_PACKET_BITS;
            next_tx_cnt = bit_len - 1'b1;
          end
        end
      end
      HCUB_TX_SEND: begin
        if (tx_cnt != '0) begin
          next_tx_cnt = tx_cnt - 1'b1;
        end else begin
          next_tx_cnt = bit_len - 1'b1;
          next_tx_shift = {1'b1, tx_shift[43:1]};
          next_tx_left = tx_left - 1'b1;
          if (tx_left == 6'h01) begin
            next_tx_state = HCUB_TX_IDLE;
          end
        end
      end
    endcase
    next_tx_pin = (next_tx_state == HCUB_TX_SEND) ? next_tx_shift[0] : 1'b1;
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tx_state <= HCUB_TX_IDLE;
      tx_cnt <= '0;
      tx_left <= 6'h00;
      tx_shift <= 44'h000_0000_0000;
      read_pend <= 1'b0;
      read_word <= 16'h0000;
      event_pend <= 1'b0;
      event_seen <= 1'b0;
      uart_tx_pin <= 1'b1;
      tx_busy <= 1'b0;
    end else if (clk_en) begin
      tx_state <= next_tx_state;
      tx_cnt <= next_tx_cnt;
      tx_left <= next_tx_left;
      tx_shift <= next_tx_shift;
      read_pend <= next_read_pend;
      read_word <= next_read_word;
      event_pend <= next_event_pend;
      event_seen <= any_event;
      uart_tx_pin <= next_tx_pin;
      tx_busy <= next_tx_state == HCUB_TX_SEND;
    end
  end

endmodule
`default_nettype wire

// >>> test/hcub_host.sv
// Host controller model driving and reading the UART lines.
`timescale 1ns/10ps
`default_nettype none
module hcub_host #(
  parameter int BIT = 16
) (
  // Clock.
  input wire logic ref_clk,
  // UART lines.
  input wire logic uart_tx_pin,
  output logic uart_rx_pin
);
  // The line idles high between characters.
  initial uart_rx_pin = 1'b1;
  // Holds the receive line at one level for whole bit periods.
  task automatic hold(input logic lvl, input int bits);
    @(posedge ref_clk);
    #1;
    uart_rx_pin = lvl;
    repeat (bits * BIT - 1) @(posedge ref_clk);
  endtask
  // Sends start, data with bit 0 first, odd parity and stop.
  task automatic send_char(input logic [7:0] d, input logic par_ok);
    hold(1'b0, 1);
    for (int i = 0; i < 8; i++) hold(d[i], 1);
    hold((~^d) ^ !par_ok, 1);
    hold(1'b1, 1);
    #1;
  endtask
  // Sends eleven low bit times, then idles before the next start.
  task automatic send_break();
    hold(1'b0, 11);
    hold(1'b1, 2);
    #1;
  endtask
  // Samples a whole packet at mid-bit and unpacks the three characters.
  task automatic recv(output logic [23:0] word, output logic ok);
    logic [43:0] b;
    @(negedge uart_tx_pin);
    repeat (BIT / 2) @(posedge ref_clk);
    for (int i = 0; i < 44; i++) begin
      b[i] = uart_tx_pin;
      repeat (BIT) @(posedge ref_clk);
    end
    ok = (b[10:0] == 11'h000);
    for (int c = 0; c < 3; c++) begin
      word[23-8*c -: 8] = b[11*c+19 -: 8];
      ok &= !b[11*c+11] && b[11*c+21] && (^b[11*c+20 -: 9]);
    end
  endtask
endmodule
`default_nettype wire

// >>> test/hcub_port_chk.sv
// Concurrent checks on the checksum and UART break command port.
`timescale 1ns/10ps
`default_nettype none
module hcub_port_chk
  import hcub_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic clk_en,
  // Configuration and strobes.
  input wire logic [ERR_CNT_W-1:0] error_limit,
  input wire logic fault_mask,
  input wire logic alarm_action_enable,
  input wire logic spi_frame_done,
  input wire logic status_read_start,
  input wire logic status_read_end,
  // Observed outputs.
  input wire logic uart_tx_pin,
  input wire logic checksum_error_status,
  input wire logic [ERR_CNT_W-1:0] checksum_error_count,
  input wire logic checksum_fault_flag,
  input wire logic alarm_irq_status,
  input wire logic alarm_pin_oe,
  input wire logic cmd_valid,
  input wire logic [6:0] cmd_addr,
  input wire logic cmd_from_uart,
  input wire logic uart_reg_access,
  input wire logic tx_busy
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  // Steps named for the properties below, each sequence used by one property.
  sequence s_bad_frame;
    clk_en && spi_frame_done ##1 checksum_error_status;
  endsequence
  sequence s_break;
    !uart_tx_pin [*8];
  endsequence
  // Error counting and rejection of failed frames.
  property p_cnt_step;
    $changed(checksum_error_count) |-> checksum_error_status &&
      checksum_error_count == $past(checksum_error_count) + 4'h1;
  endproperty
  a_cnt_step: assert property (p_cnt_step) else $error("count step wrong");
  property p_no_exec;
    s_bad_frame |=> !cmd_valid;
  endproperty
  a_no_exec: assert property (p_no_exec) else $error("failed frame executed");
  property p_status_hold;
    !(clk_en && spi_frame_done) |=> $stable(checksum_error_status);
  endproperty
  a_status_hold: assert property (p_status_hold) else $error("status moved");
  // Fault flag setting, clearing and alarm outputs.
  property p_fault_set;
    $changed(checksum_error_count) && checksum_error_count == error_limit &&
      error_limit != 4'h0 |-> ##[0:1] checksum_fault_flag;
  endproperty
  a_fault_set: assert property (p_fault_set) else $error("fault not set");
  // Alarm outputs load with the flag, so they track it edge for edge, clears included.
  property p_alarm;
    clk_en |=> alarm_irq_status == (checksum_fault_flag && !$past(fault_mask)) &&
      alarm_pin_oe == (alarm_irq_status && $past(alarm_action_enable));
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm not raised");
  property p_sticky;
    $fell(checksum_fault_flag) |-> $past(status_read_start);
  endproperty
  a_sticky: assert property (p_sticky) else $error("fault cleared early");
  property p_relatch;
    clk_en && status_read_end && error_limit != 4'h0 &&
      checksum_error_count >= error_limit |=> checksum_fault_flag;
  endproperty
  a_relatch: assert property (p_relatch) else $error("fault not relatched");
  // Register access hand-over and outgoing break.
  property p_access;
    $changed(uart_reg_access) |-> cmd_valid && cmd_from_uart && cmd_addr == BREAK_REG_ADDR;
  endproperty
  a_access: assert property (p_access) else $error("access bit moved");
  property p_tx_break;
    $rose(tx_busy) |-> ##[0:2] s_break;
  endproperty
  a_tx_break: assert property (p_tx_break) else $error("packet without break");
endmodule
bind hcub_port hcub_port_chk hcub_port_chk_i (.*);
`default_nettype wire

// >>> test/test_hcub_port.sv
// Self-checking bench for the checksum and UART break command port.
`timescale 1ns/10ps
`default_nettype none
module test_hcub_port;
  import hcub_pkg::*;
  // Design inputs and outputs, plus bench bookkeeping.
  logic ref_clk, resetn, clk_en, checksum_enable, fault_mask, alarm_action_enable;
  logic uart_fast_baud, break_event_enable, spi_frame_done, status_read_start;
  logic status_read_end, alarm_event_flag, general_event_flag, modem_event_flag;
  logic read_resp_valid, uart_rx_pin, uart_tx_pin, checksum_error_status;
  logic checksum_fault_flag, alarm_irq_status, alarm_pin_out, alarm_pin_oe, cmd_valid;
  logic cmd_read, cmd_from_uart, uart_reg_access, modem_rx_valid, uart_parity_error;
  logic uart_stop_error, tx_busy, rx_ok;
  logic [ERR_CNT_W-1:0] error_limit, checksum_error_count;
  logic [31:0] spi_frame_bits, spi_out_frame;
  logic [23:0] spi_read_data, rx_word;
  logic [15:0] alarm_status_word, general_state_register, modem_status_word;
  logic [15:0] read_resp_word, cmd_data;
  logic [6:0] cmd_addr;
  logic [7:0] modem_rx_data;
  logic [3:0] seen;
  int err_count, checks;
  // Device with short bit periods, and the host model.
  hcub_port #(.BIT_FAST(18'h10), .BIT_SLOW(18'h20)) hcub_port_i (.*);
  hcub_host #(.BIT(16)) hcub_host_i (.ref_clk(ref_clk), .uart_tx_pin(uart_tx_pin),
    .uart_rx_pin(uart_rx_pin));
  // Clock, and a record of pulses seen since the last clear.
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) seen <= seen |
    {cmd_valid, modem_rx_valid, uart_parity_error, uart_stop_error};
  // Frame checksum over 24 payload bits.
  function automatic logic [7:0] crc8(input logic [23:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 23; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? CRC_POLY[7:0] : 8'h00);
    return c;
  endfunction
  // Bus helpers; tick, frame and tx_expect end one delay step after a clock edge.
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic frame(input logic [31:0] bits);
    spi_frame_bits = bits;
    spi_frame_done = 1'b1;
    tick(1);
    spi_frame_done = 1'b0;
    seen = 4'h0;
  endtask
  task automatic tx_expect(input logic [23:0] exp);
    fork
      hcub_host_i.recv(rx_word, rx_ok);
      begin
        tick(1);
        read_resp_valid = 1'b0;
      end
    join
    tick(0);
    cmp("tx break", 1, rx_ok);
    cmp("tx word", exp, rx_word);
  endtask
  task automatic conclude();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Watchdog against a hang.
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    conclude();
  end
  // Main sequence.
  initial begin
    {ref_clk, resetn, fault_mask, break_event_enable, spi_frame_done} = 5'h00;
    {status_read_start, status_read_end, read_resp_valid, modem_event_flag} = 4'h0;
    {alarm_event_flag, general_event_flag, seen, err_count, checks} = 0;
    {clk_en, checksum_enable, uart_fast_baud, alarm_action_enable} = 4'hf;
    {error_limit, spi_frame_bits, read_resp_word, modem_status_word} = 0;
    spi_read_data = 24'h12a5c3;
    alarm_status_word = 16'h0911;
    general_state_register = 16'h0042;
    error_limit = 4'h2;
    tick(10);
    resetn = 1'b1;
    tick(2);
    cmp("readback", {spi_read_data, crc8(spi_read_data)}, spi_out_frame);
    frame({24'h05beef, crc8(24'h05beef)});
    cmp("crc status", 0, checksum_error_status);
    tick(2);
    cmp("command", {2'h2, 7'h05, 16'hbeef}, {seen[3], cmd_read, cmd_addr, cmd_data});
    for (int i = 1; i <= 2; i++) begin
      frame({24'h05beef, crc8(24'h05beef) ^ 8'h01});
      cmp("error count", {1'b1, 4'(i)}, {checksum_error_status, checksum_error_count});
      tick(2);
      cmp("rejected", 0, seen[3]);
    end
    tick(2);
    cmp("alarm", 4'he, {checksum_fault_flag, alarm_irq_status, alarm_pin_oe, alarm_pin_out});
    frame({24'h05beef, crc8(24'h05beef)});
    cmp("crc status", 0, checksum_error_status);
    status_read_start = 1'b1;
    tick(1);
    status_read_start = 1'b0;
    cmp("fault cleared", 0, checksum_fault_flag);
    status_read_end = 1'b1;
    tick(1);
    status_read_end = 1'b0;
    cmp("fault relatched", 1, checksum_fault_flag);
    fault_mask = 1'b1;
    tick(2);
    cmp("masked alarm", 0, alarm_irq_status);
    // A failed frame while the enable is low must leave the count alone.
    clk_en = 1'b0;
    frame({24'h05beef, crc8(24'h05beef) ^ 8'h01});
    cmp("frozen count", 4'h2, checksum_error_count);
    clk_en = 1'b1;
    {checksum_enable, uart_fast_baud} = 2'h0;
    tick(2);
    cmp("plain readback", {8'h00, spi_read_data}, spi_out_frame);
    frame({8'h00, 24'h8a1234});
    tick(2);
    cmp("plain command", {2'h3, 7'h0a}, {seen[3], cmd_read, cmd_addr});
    {checksum_enable, uart_fast_baud} = 2'h3;
    tick(2);
    seen = 4'h0;
    hcub_host_i.send_char(8'h3c, 1'b1);
    cmp("modem byte", {4'h4, 8'h3c}, {seen, modem_rx_data});
    seen = 4'h0;
    hcub_host_i.send_char(8'h3c, 1'b0);
    cmp("parity error", 4'h2, seen);
    seen = 4'h0;
    hcub_host_i.send_break();
    hcub_host_i.send_char(8'h7e, 1'b1);
    hcub_host_i.send_char(8'h00, 1'b1);
    hcub_host_i.send_char(8'h01, 1'b1);
    tick(4);
    cmp("uart write", {4'h8, 2'h3}, {seen, cmd_from_uart, uart_reg_access});
    frame({24'h05beef, crc8(24'h05beef)});
    tick(2);
    cmp("spi locked", 0, seen[3]);
    read_resp_word = 16'ha55a;
    read_resp_valid = 1'b1;
    tx_expect(24'h80a55a);
    break_event_enable = 1'b1;
    {alarm_event_flag, general_event_flag} = 2'h3;
    tx_expect(24'h600911);
    conclude();
  end
endmodule
`default_nettype wire
